// File: pkg/shp_pkg.sv
package shp_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int SHP_BYTE_W  = 8;
    localparam int SHP_STAT_W  = 8;
    localparam int SHP_BCNT_W  = 3;
    localparam int SHP_DCNT_W  = 4;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SHP_RD_FLAG_BIT = 7;          // First byte MSB asks for read data

    // ****************************************************************
    // Reset values and last bit count
    // ****************************************************************
    localparam logic                  SHP_FOUR_WIRE_RST = 1'b1;
    localparam logic                  SHP_IRQ_N_RST     = 1'b1;
    localparam logic                  SHP_SEL_SYNC_RST  = 1'b1;  // Pin is pulled up
    localparam logic                  SHP_PIN_SYNC_RST  = 1'b1;
    localparam logic [1:0]            SHP_ADDR_RST      = 2'h0;
    localparam logic [SHP_BYTE_W-1:0] SHP_BYTE_RST      = 8'h00;
    localparam logic [SHP_STAT_W-1:0] SHP_STAT_RST      = 8'h00;
    localparam logic [SHP_BCNT_W-1:0] SHP_BCNT_LAST     = 3'h7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SHP_CLK_PERIOD_NS = 20;
    localparam int SHP_CLK_EN_DLY_NS = 100;      // Least hold of clock outputs after reset
    localparam int SHP_CLK_EN_CYC    =
        (SHP_CLK_EN_DLY_NS + SHP_CLK_PERIOD_NS - 1) / SHP_CLK_PERIOD_NS;

    // ****************************************************************
    // States
    // ****************************************************************
    typedef enum logic [1:0] {
        SHP_ST_HOLD,
        SHP_ST_WAIT,
        SHP_ST_RUN
    } shp_state_t;

endpackage

// File: pkg/shp_link_if.sv
`timescale 1ns/1ps
interface shp_link_if;
    import shp_pkg::*;

    // Core to link, quasi-static or toggle handshaked
    logic                  mode_i2c;
    logic [SHP_BYTE_W-1:0] tx_byte;
    logic                  tx_tog;
    // Link to core
    logic [SHP_BYTE_W-1:0] rx_byte;
    logic                  rx_tog;
    logic                  tx_ack;
    logic                  frame_act;
    logic                  rd_phase;
    logic                  rd_bit;

    modport core (
        output mode_i2c, tx_byte, tx_tog,
        input  rx_byte, rx_tog, tx_ack, frame_act, rd_phase, rd_bit
    );
    modport link (
        input  mode_i2c, tx_byte, tx_tog,
        output rx_byte, rx_tog, tx_ack, frame_act, rd_phase, rd_bit
    );
endinterface

// File: rtl/shp_link.sv
`timescale 1ns/1ps
module shp_link
    import shp_pkg::*;
(
    input  wire logic sclk_link,
    input  wire logic arst_n,
    input  wire logic select_pin,
    input  wire logic data_in,
    shp_link_if.link  lnk
);

    logic                  frame_rst_n;
    logic [SHP_BCNT_W-1:0] bit_cnt_reg;
    logic [SHP_BYTE_W-1:0] shift_reg;
    logic [SHP_BYTE_W-1:0] out_shift_reg;
    logic                  first_reg;
    logic                  frame_act_reg;
    logic                  rd_phase_reg;
    logic [SHP_BYTE_W-1:0] rx_byte_reg;
    logic                  rx_tog_reg;
    logic                  tx_tog_s1_reg;
    logic                  tx_tog_s2_reg;
    logic                  tx_ack_reg;
    logic [SHP_BYTE_W-1:0] tx_word_reg;
    logic                  byte_done;

    // ****************************************************************
    // Framing
    // ****************************************************************
    // Select high in SPI holds the frame logic cleared, so the bus is ignored
    assign frame_rst_n = arst_n & (lnk.mode_i2c | ~select_pin);  // R9
    assign byte_done   = (bit_cnt_reg == SHP_BCNT_LAST);

    // Bit shifter on the host's clock
    always_ff @(posedge sclk_link or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg   <= '0;
            shift_reg     <= SHP_BYTE_RST;
            out_shift_reg <= SHP_BYTE_RST;
            first_reg     <= 1'b1;
            frame_act_reg <= 1'b0;
            rd_phase_reg  <= 1'b0;
        end else begin
            frame_act_reg <= 1'b1;
            bit_cnt_reg   <= bit_cnt_reg + 3'h1;
            shift_reg     <= {shift_reg[SHP_BYTE_W-2:0], data_in};  // R7
            if (byte_done) begin
                first_reg     <= 1'b0;
                out_shift_reg <= tx_word_reg;
                if (first_reg && shift_reg[SHP_RD_FLAG_BIT-1]) begin
                    rd_phase_reg <= 1'b1;
                end
            end else begin
                out_shift_reg <= {out_shift_reg[SHP_BYTE_W-2:0], 1'b0};
            end
        end
    end

    // Completed byte held for the core, flagged by toggle
    always_ff @(posedge sclk_link or negedge arst_n) begin
        if (!arst_n) begin
            rx_byte_reg <= SHP_BYTE_RST;
            rx_tog_reg  <= 1'b0;
        end else if (frame_rst_n && byte_done) begin
            rx_byte_reg <= {shift_reg[SHP_BYTE_W-2:0], data_in};
            rx_tog_reg  <= ~rx_tog_reg;
        end
    end

    // Read word crossing from the core
    always_ff @(posedge sclk_link or negedge arst_n) begin
        if (!arst_n) begin
            tx_tog_s1_reg <= 1'b0;
            tx_tog_s2_reg <= 1'b0;
            tx_ack_reg    <= 1'b0;
            tx_word_reg   <= SHP_BYTE_RST;
        end else begin
            tx_tog_s1_reg <= lnk.tx_tog;
            tx_tog_s2_reg <= tx_tog_s1_reg;
            if (tx_tog_s2_reg != tx_ack_reg) begin
                tx_word_reg <= lnk.tx_byte;
                tx_ack_reg  <= tx_tog_s2_reg;
            end
        end
    end

    assign lnk.rx_byte   = rx_byte_reg;
    assign lnk.rx_tog    = rx_tog_reg;
    assign lnk.tx_ack    = tx_ack_reg;
    assign lnk.frame_act = frame_act_reg;
    assign lnk.rd_phase  = rd_phase_reg;
    assign lnk.rd_bit    = out_shift_reg[SHP_BYTE_W-1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    select_frame_a: assert property (  // R9
        @(posedge sclk_link) disable iff (!arst_n)
        frame_act_reg |-> (lnk.mode_i2c || !select_pin))
        else $error("frame active while select is high in SPI");

    bit_shift_a: assert property (  // R7
        @(posedge sclk_link) disable iff (!frame_rst_n)
        frame_act_reg |=> shift_reg[0] == $past(data_in))
        else $error("data bit not shifted on serial clock");

endmodule // shp_link

// File: rtl/shp_pin_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Select input high picks I2C, low SPI
// R2: I2C mode: data pin is I2C data
// R3: Three-wire SPI: data pin carries both directions
// R4: Four-wire SPI: data pin is input only
// R5: I2C mode: address-one pin gives address bit one
// R6: Four-wire SPI: address-one pin drives read data
// R7: Host serial clock used in both modes
// R8: I2C mode: address-zero pin strapped bit zero
// R9: SPI mode: select low frames, high ignored
// R10: Interrupt output low on any status change
// R11: Interrupt output is push-pull, always driven
// R12: Reset input low gives full power-up reset
// R13: Reset restores logic and configuration defaults
// R14: Clock outputs disabled while reset is active
// R15: Three/four-wire SPI from one held setting
module shp_pin_select
    import shp_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  sclk_link,
    input  wire logic                  i2c_sel_pin,
    input  wire logic                  data_pin_in,
    output logic                       data_pin_out,
    output logic                       data_pin_oe,
    input  wire logic                  addr1_or_read_out_pin_in,
    output logic                       addr1_or_read_out_pin_out,
    output logic                       addr1_or_read_out_pin_oe,
    input  wire logic                  addr0_or_select_pin,
    input  wire logic                  four_wire_cfg,
    input  wire logic                  four_wire_load,
    input  wire logic [SHP_STAT_W-1:0] status_in,
    input  wire logic                  status_ack,
    input  wire logic [SHP_BYTE_W-1:0] tx_byte,
    input  wire logic                  tx_load,
    output logic                       tx_ready,
    output logic [SHP_BYTE_W-1:0]      rx_byte,
    output logic                       rx_valid,
    output logic                       i2c_mode,
    output logic                       four_wire,
    output logic [1:0]                 bus_addr,
    output logic                       status_change_irq_n,
    output logic                       clk_out_en
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    shp_link_if lnk ();

    shp_state_t            state_reg;
    shp_state_t            state_next;
    logic [SHP_DCNT_W-1:0] dly_cnt_reg;
    logic                  rst_s1_reg;
    logic                  rst_sync_reg;
    logic                  sel_s1_reg;
    logic                  sel_s2_reg;
    logic                  a0_s1_reg;
    logic                  a0_s2_reg;
    logic                  a1_s1_reg;
    logic                  a1_s2_reg;
    logic                  mode_i2c_reg;
    logic                  four_wire_reg;
    logic [1:0]            bus_addr_reg;
    logic [SHP_STAT_W-1:0] status_prev_reg;
    logic                  irq_pend_reg;
    logic                  status_change;
    logic                  clk_en_reg;
    logic                  rx_s1_reg;
    logic                  rx_s2_reg;
    logic                  rx_s3_reg;
    logic [SHP_BYTE_W-1:0] rx_byte_reg;
    logic                  rx_valid_reg;
    logic [SHP_BYTE_W-1:0] tx_byte_reg;
    logic                  tx_tog_reg;
    logic                  ack_s1_reg;
    logic                  ack_s2_reg;
    logic                  spi_mode;

    // ****************************************************************
    // Link side
    // ****************************************************************
    // Shifter running on the host's serial clock
    shp_link u_link (
        .sclk_link  (sclk_link),
        .arst_n     (arst_n),
        .select_pin (addr0_or_select_pin),
        .data_in    (data_pin_in),
        .lnk        (lnk)
    );

    assign lnk.mode_i2c  = mode_i2c_reg;
    assign lnk.tx_byte   = tx_byte_reg;
    assign lnk.tx_tog    = tx_tog_reg;

    // ****************************************************************
    // Reset release and clock output enable
    // ****************************************************************
    // The device reset input is arst_n itself; release is synchronised
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin  // R12
            rst_s1_reg   <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_s1_reg   <= 1'b1;
            rst_sync_reg <= rst_s1_reg;
        end
    end

    // Next state of the bring-up sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SHP_ST_HOLD: begin
                if (rst_sync_reg) begin
                    state_next = SHP_ST_WAIT;
                end
            end
            SHP_ST_WAIT: begin
                if (dly_cnt_reg == SHP_DCNT_W'(SHP_CLK_EN_CYC - 1)) begin
                    state_next = SHP_ST_RUN;
                end
            end
            SHP_ST_RUN: begin
                state_next = SHP_ST_RUN;
            end
        endcase
    end

    // State and hold counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin  // R13
            state_reg   <= SHP_ST_HOLD;
            dly_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == SHP_ST_WAIT) begin
                dly_cnt_reg <= dly_cnt_reg + 4'h1;
            end
        end
    end

    // Clock outputs stay off through reset and the hold time
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_en_reg <= 1'b0;  // R14
        end else begin
            clk_en_reg <= (state_next == SHP_ST_RUN);
        end
    end

    // ****************************************************************
    // Mode and strap pins
    // ****************************************************************
    // Two-stage synchronisers for the board-level pins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_s1_reg <= SHP_SEL_SYNC_RST;
            sel_s2_reg <= SHP_SEL_SYNC_RST;
            a0_s1_reg  <= SHP_PIN_SYNC_RST;
            a0_s2_reg  <= SHP_PIN_SYNC_RST;
            a1_s1_reg  <= SHP_PIN_SYNC_RST;
            a1_s2_reg  <= SHP_PIN_SYNC_RST;
        end else begin
            sel_s1_reg <= i2c_sel_pin;
            sel_s2_reg <= sel_s1_reg;
            a0_s1_reg  <= addr0_or_select_pin;
            a0_s2_reg  <= a0_s1_reg;
            a1_s1_reg  <= addr1_or_read_out_pin_in;
            a1_s2_reg  <= a1_s1_reg;
        end
    end

    // Interface style follows the select pin
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_i2c_reg <= SHP_SEL_SYNC_RST;
        end else begin
            mode_i2c_reg <= sel_s2_reg;  // R1
        end
    end

    // Address straps caught once, at the end of the hold time, and only when the select pin picks I2C
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_addr_reg <= SHP_ADDR_RST;
        end else if (state_reg == SHP_ST_WAIT && state_next == SHP_ST_RUN
                     && sel_s2_reg) begin
            bus_addr_reg[1] <= a1_s2_reg;  // R5
            bus_addr_reg[0] <= a0_s2_reg;  // R8
        end
    end

    // Three or four wire, one setting at a time
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            four_wire_reg <= SHP_FOUR_WIRE_RST;  // R13
        end else if (four_wire_load) begin
            four_wire_reg <= four_wire_cfg;  // R15
        end
    end

    // ****************************************************************
    // Pin roles
    // ****************************************************************
    assign spi_mode = ~mode_i2c_reg;

    // Data pin: I2C data, SPI bidirectional data, or SPI input only
    always_comb begin
        data_pin_out = lnk.rd_bit;
        data_pin_oe  = 1'b0;  // R2 R4
        if (spi_mode && !four_wire_reg) begin
            data_pin_oe = lnk.frame_act & lnk.rd_phase;  // R3
        end
    end

    // Address-one pin: strap input, or read data driven in four wire
    always_comb begin
        addr1_or_read_out_pin_out = lnk.rd_bit;
        addr1_or_read_out_pin_oe  = 1'b0;  // R5
        if (spi_mode && four_wire_reg) begin
            addr1_or_read_out_pin_oe = lnk.frame_act;  // R6
        end
    end

    // ****************************************************************
    // Status change interrupt
    // ****************************************************************
    assign status_change = |(status_in ^ status_prev_reg);

    // Sticky pending flag; a change wins over an acknowledge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_prev_reg <= SHP_STAT_RST;
            irq_pend_reg    <= 1'b0;
        end else begin
            status_prev_reg <= status_in;
            if (status_change) begin
                irq_pend_reg <= 1'b1;  // R10
            end else if (status_ack) begin
                irq_pend_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Byte crossings
    // ****************************************************************
    // Received byte toggle into the core clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1_reg    <= 1'b0;
            rx_s2_reg    <= 1'b0;
            rx_s3_reg    <= 1'b0;
            rx_byte_reg  <= SHP_BYTE_RST;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_s1_reg    <= lnk.rx_tog;
            rx_s2_reg    <= rx_s1_reg;
            rx_s3_reg    <= rx_s2_reg;
            rx_valid_reg <= rx_s2_reg ^ rx_s3_reg;
            if (rx_s2_reg ^ rx_s3_reg) begin
                rx_byte_reg <= lnk.rx_byte;
            end
        end
    end

    // Read word offered to the link by toggle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_reg  <= 1'b0;
            ack_s2_reg  <= 1'b0;
            tx_byte_reg <= SHP_BYTE_RST;
            tx_tog_reg  <= 1'b0;
        end else begin
            ack_s1_reg <= lnk.tx_ack;
            ack_s2_reg <= ack_s1_reg;
            if (tx_load && tx_ready) begin
                tx_byte_reg <= tx_byte;
                tx_tog_reg  <= ~tx_tog_reg;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign tx_ready            = (tx_tog_reg == ack_s2_reg);
    assign rx_byte             = rx_byte_reg;
    assign rx_valid            = rx_valid_reg;
    assign i2c_mode            = mode_i2c_reg;
    assign four_wire           = four_wire_reg;
    assign bus_addr            = bus_addr_reg;
    assign status_change_irq_n = ~irq_pend_reg;  // R11
    assign clk_out_en          = clk_en_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    mode_follow_a: assert property (  // R1
        @(posedge ref_clk) disable iff (!arst_n)
        $past(arst_n, 1) && $past(arst_n, 2) && $past(arst_n, 3)
        |-> i2c_mode == $past(i2c_sel_pin, 3))
        else $error("mode does not follow select pin");

    i2c_pins_a: assert property (  // R2
        @(posedge ref_clk) disable iff (!arst_n)
        i2c_mode |-> !data_pin_oe && !addr1_or_read_out_pin_oe)
        else $error("pin driven in I2C mode");

    three_wire_a: assert property (  // R3
        @(posedge ref_clk) disable iff (!arst_n)
        (!i2c_mode && !four_wire && lnk.frame_act && lnk.rd_phase)
        |-> data_pin_oe && !addr1_or_read_out_pin_oe
            && data_pin_out == lnk.rd_bit)
        else $error("three wire read data not on data pin");

    four_wire_a: assert property (  // R4
        @(posedge ref_clk) disable iff (!arst_n)
        (!i2c_mode && four_wire && lnk.frame_act)
        |-> !data_pin_oe && addr1_or_read_out_pin_oe)
        else $error("four wire pin roles wrong");

    addr_hold_a: assert property (  // R8
        @(posedge ref_clk) disable iff (!arst_n)
        (state_reg == SHP_ST_RUN && $past(state_reg) == SHP_ST_RUN) |-> $stable(bus_addr))
        else $error("strapped address changed while running");

    irq_set_a: assert property (  // R10
        @(posedge ref_clk) disable iff (!arst_n)
        status_change |=> !status_change_irq_n)
        else $error("interrupt not asserted on status change");

    irq_hold_a: assert property (  // R10
        @(posedge ref_clk) disable iff (!arst_n)
        (!status_change_irq_n && !status_ack) |=> !status_change_irq_n)
        else $error("interrupt released without acknowledge");

    reset_dflt_a: assert property (  // R13
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(rst_sync_reg) |-> $past(status_change_irq_n, 2) && !$past(clk_out_en, 2)
            && $past(four_wire, 2) == SHP_FOUR_WIRE_RST && $past(bus_addr, 2) == SHP_ADDR_RST)
        else $error("defaults not restored by reset");

    clk_en_a: assert property (  // R14
        @(posedge ref_clk) disable iff (!arst_n)
        clk_out_en |-> rst_sync_reg && $past(rst_sync_reg, 5))
        else $error("clock outputs enabled too soon after reset");

    rx_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        rx_valid |=> !rx_valid)
        else $error("received byte flag longer than one cycle");

endmodule // shp_pin_select

// File: test/shp_host_model.sv
`timescale 1ns/1ps
module shp_host_model (
    output logic      sclk,
    output logic      sel_n,
    output logic      mosi,
    output logic      mosi_oe,
    input  wire logic miso
);
    // Idle bus: clock still, select off
    initial begin
        sclk    = 1'b0;
        sel_n   = 1'b1;
        mosi    = 1'b0;
        mosi_oe = 1'b1;
    end
    // Two-byte frame, MSB first, data set on falling edge
    task automatic frame(input logic [15:0] bits, input logic rel, input logic off,
                         output logic [7:0] got);
        #13 sel_n = off;
        for (int i = 15; i >= 0; i--) begin
            mosi_oe = !(rel && i < 8);
            mosi    = bits[i];
            #40 if (i < 8) got[i] = miso;
            sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 sel_n = 1'b1;
        mosi_oe = 1'b1;
    endtask
endmodule // shp_host_model

// File: test/shp_pin_select_tb.sv
`timescale 1ns/1ps
module shp_pin_select_tb;
    import shp_pkg::*;
    logic       ref_clk = 1'b0, arst_n = 1'b0, i2c_sel = 1'b1, fw_cfg = 1'b0, fw_load = 1'b0;
    logic       ack = 1'b0, tx_load = 1'b0, sclk, sel_n, hd, hoe, d_out, d_oe, a1_out, a1_oe;
    logic       i2c_m, fw, irq_n, ck_en, tx_rdy, rx_v;
    logic [7:0] status = 8'h00, tx_b = 8'h00, got, rx_last, rx_b;
    logic [1:0] baddr, oe_seen = 2'h0;
    int         num_errors = 0, comparisons = 0, rx_cnt = 0;
    wire        dwire = d_oe ? d_out : (hoe ? hd : ~hd);

    always #10 ref_clk = ~ref_clk;

    shp_host_model host (.sclk(sclk), .sel_n(sel_n), .mosi(hd), .mosi_oe(hoe),
                         .miso(a1_oe ? a1_out : dwire));
    shp_pin_select dut (.ref_clk(ref_clk), .arst_n(arst_n), .sclk_link(sclk),
        .i2c_sel_pin(i2c_sel), .data_pin_in(dwire), .data_pin_out(d_out), .data_pin_oe(d_oe),
        .addr1_or_read_out_pin_in(1'b1), .addr1_or_read_out_pin_out(a1_out),
        .addr1_or_read_out_pin_oe(a1_oe), .addr0_or_select_pin(i2c_sel ? 1'b0 : sel_n),
        .four_wire_cfg(fw_cfg), .four_wire_load(fw_load), .status_in(status),
        .status_ack(ack), .tx_byte(tx_b), .tx_load(tx_load), .tx_ready(tx_rdy),
        .rx_byte(rx_b), .rx_valid(rx_v), .i2c_mode(i2c_m), .four_wire(fw), .bus_addr(baddr),
        .status_change_irq_n(irq_n), .clk_out_en(ck_en));

    // Received bytes and pin drive seen
    always @(posedge ref_clk) begin
        if (rx_v === 1'b1) begin
            rx_last <= rx_b;
            rx_cnt  <= rx_cnt + 1;
        end
        oe_seen <= oe_seen | {d_oe === 1'b1, a1_oe === 1'b1};
    end

    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task end_sim;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 200 && s !== v; i++) step(1);
        if (s !== v) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic wait_rx(input int n);
        for (int i = 0; i < 200 && rx_cnt < n; i++) step(1);
        chk("rx count", n, rx_cnt);
    endtask

    // Values held in reset, outputs off, straps taken
    task reset_seq;
        step(2);
        chk("clk_out_en", 8'h0, ck_en);
        chk("irq_n", 8'h1, irq_n);
        chk("four_wire", 8'h1, fw);
        chk("pin oe", 8'h0, {d_oe, a1_oe});
        arst_n = 1'b1;
        step(5);
        chk("clk_out_en hold", 8'h0, ck_en);
        wait_lvl(ck_en, 1'b1);
        chk("bus_addr", 8'h2, baddr);
        chk("i2c_mode", 8'h1, i2c_m);
        i2c_sel = 1'b0;
        step(5);
        chk("spi mode", 8'h0, i2c_m);
    endtask
    // Raise, clear, and change beating clear
    task irq_seq;
        status = 8'h01;
        step(2);
        chk("irq set", 8'h0, irq_n);
        ack = 1'b1;
        step(1);
        chk("irq clear", 8'h1, irq_n);
        status = 8'h03;
        step(1);
        chk("change wins", 8'h0, irq_n);
        ack = 1'b0;
        step(1);
        chk("irq hold", 8'h0, irq_n);
    endtask
    // Write frame, then frame with select high
    task write_seq;
        host.frame(16'h5A3C, 1'b0, 1'b0, got);
        wait_rx(2);
        chk("rx byte", 8'h3C, rx_last);
        host.frame(16'hFFFF, 1'b0, 1'b1, got);
        step(20);
        chk("ignored", 8'h2, rx_cnt);
    endtask
    // Read frame in the given wire style
    task automatic read_seq(input logic fourw, input logic [7:0] val, input int n);
        fw_cfg  = fourw;
        fw_load = 1'b1;
        step(1);
        fw_load = 1'b0;
        step(1);
        chk("four_wire", {7'h0, fourw}, fw);
        oe_seen = 2'h0;
        wait_lvl(tx_rdy, 1'b1);
        tx_b    = val;
        tx_load = 1'b1;
        step(1);
        tx_load = 1'b0;
        host.frame(16'h8000, !fourw, 1'b0, got);
        chk("read data", val, got);
        chk("pins driven", fourw ? 8'h1 : 8'h2, oe_seen);
        wait_rx(n);
    endtask
    // Reset in mid-run brings back power-up values
    task reset_again;
        arst_n = 1'b0;
        step(1);
        chk("irq_n in reset", 8'h1, irq_n);
        chk("four_wire in reset", 8'h1, fw);
        chk("mode in reset", 8'h1, i2c_m);
        chk("clk_out_en in reset", 8'h0, ck_en);
        arst_n = 1'b1;
        wait_lvl(ck_en, 1'b1);
        chk("spi mode again", 8'h0, i2c_m);
        chk("bus_addr in spi", 8'h0, baddr);
    endtask

    initial begin
        reset_seq();
        irq_seq();
        write_seq();
        read_seq(1'b1, 8'hC3, 4);
        read_seq(1'b0, 8'hA5, 6);
        reset_again();
        end_sim();
    end
endmodule // shp_pin_select_tb
